/* File: rtl/ompc_pkg.sv */
// package for the operating mode and priority control block
// assumes a single 25 MHz system clock domain and an axi4-lite register slave
package ompc_pkg;
    // register map (byte address)
    localparam logic [15:0] OMPC_PRIO_MODE_ADDR = 16'h103C; // priority_and_mode_control
    localparam logic [15:0] OMPC_STATUS_ADDR = 16'h1040; // mode status, read only
    // field positions of the control register
    localparam int OMPC_BOOT_BIT = 7;
    localparam int OMPC_SPECIAL_MODE_BIT_BIT = 6;
    localparam int OMPC_MDA_BIT = 5;
    localparam int OMPC_IRV_BIT = 4;
    localparam int OMPC_PSEL_MSB = 3;
    // reset value of the priority select field
    localparam logic [3:0] OMPC_PSEL_RST = 4'h6;
    // reset vector areas
    localparam logic [15:0] OMPC_NORM_VEC_LO = 16'hFFFA;
    localparam logic [15:0] OMPC_NORM_VEC_HI = 16'hFFFF;
    localparam logic [15:0] OMPC_SPEC_VEC_LO = 16'hBFFA;
    localparam logic [15:0] OMPC_SPEC_VEC_HI = 16'hBFFF;
    // boot rom window
    localparam logic [15:0] OMPC_BOOT_LO = 16'hBF00;
    localparam logic [15:0] OMPC_BOOT_HI = 16'hBFFF;
    // axi responses
    localparam logic [1:0] OMPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] OMPC_RESP_SLVERR = 2'h2;
    // operating modes, encoded as {special_mode_bit, mode_select_a}
    typedef enum logic [1:0] {
        OMPC_SINGLE_CHIP = 2'h0,
        OMPC_EXPANDED = 2'h1,
        OMPC_BOOTSTRAP = 2'h2,
        OMPC_SPECIAL_TEST = 2'h3
    } ompc_mode_t;
endpackage

/* File: rtl/ompc_sync.sv */
// two flip-flop synchroniser for the mode pins
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/1ns
module ompc_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage
    logic [WIDTH-1:0] sync_q; // second stage

    // plain double flop; reset only clears both stages
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // ompc_sync

/* File: rtl/ompc_map.sv */
// memory map decode helper: boot rom hit and reset vector window
// assumes the control state comes from the register core on the same clock
`timescale 1ns/1ns
module ompc_map (
    // control state
    input wire logic boot_rom_enable_i,
    input wire logic special_mode_i,
    // cpu address to classify
    input wire logic [15:0] cpu_addr_i,
    // decode results
    output logic boot_rom_sel_o,
    output logic [15:0] reset_vec_lo_o,
    output logic [15:0] reset_vec_hi_o
);
    import ompc_pkg::*;

    // rom answers only while enabled and inside its window
    always_comb begin
        boot_rom_sel_o = boot_rom_enable_i && (cpu_addr_i >= OMPC_BOOT_LO) && (cpu_addr_i <= OMPC_BOOT_HI); // [R06]
    end

    // vector area follows the special mode bit
    always_comb begin
        if (special_mode_i) begin
            reset_vec_lo_o = OMPC_SPEC_VEC_LO; // [R02]
            reset_vec_hi_o = OMPC_SPEC_VEC_HI;
        end else begin
            reset_vec_lo_o = OMPC_NORM_VEC_LO; // [R01]
            reset_vec_hi_o = OMPC_NORM_VEC_HI;
        end
    end
endmodule // ompc_map

/* File: rtl/ompc_top.sv */
// operating mode and interrupt priority control register with axi4-lite slave
// assumes mode pins are asynchronous and held stable across reset release
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// [R01] mode pin B high: normal, vector FFFA-FFFF
// [R02] mode pin B low: special vector BFFA-BFFF
// [R03] 8-bit register: boot, special_mode_bit, mda, irv, psel
// [R04] reset values follow mode; psel resets 0110
// [R05] boot enable readable; written only in special
// [R06] boot enable maps rom at BF00-BFFF
// [R07] reset release loads special_mode_bit=~B, mda=A
// [R08] special_mode_bit/mda writable only in special modes
// [R09] cleared special_mode_bit cannot be set again
// [R10] irv free in special, once in normal
// [R11] irv drives internal reads in expanded/test
// [R12] forbidden bits hold, allowed bits still update
module ompc_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // mode pins
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    // cpu side
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_int_read_i,
    output logic boot_rom_sel_o,
    output logic read_visible_o,
    output logic [15:0] reset_vec_lo_o,
    output logic [15:0] reset_vec_hi_o,
    output logic [3:0] prio_select_o,
    output ompc_pkg::ompc_mode_t mode_o,
    output logic mode_valid_o,
    // axi4-lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import ompc_pkg::*;

    // pin synchroniser outputs
    logic [1:0] pins_sync; // {b, a}

    // register fields
    logic boot_q, boot_d; // boot_rom_enable
    logic special_mode_bit_q, special_mode_bit_d; // special_mode_bit
    logic mda_q, mda_d; // mode_select_a
    logic irv_q, irv_d; // internal_read_visibility
    logic [3:0] psel_q, psel_d; // priority select
    logic irv_done_q, irv_done_d; // normal-mode write-once spent
    logic strap_q, strap_d; // strap capture still pending
    logic [1:0] settle_q, settle_d; // waits for synchroniser to fill

    // axi slave state
    logic [15:0] awaddr_q, awaddr_d;
    logic aw_have_q, aw_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic w_have_q, w_have_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // write strobe into the register
    logic wr_fire; // both halves present, response slot free
    logic wr_hit; // hits the control register

    // register contents as one byte
    function automatic logic [7:0] pack_reg(input logic b, input logic s, input logic m,
                                            input logic i, input logic [3:0] p);
        pack_reg = {b, s, m, i, p}; // [R03]
    endfunction

    ompc_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({mode_pin_b_i, mode_pin_a_i}),
        .sync_o(pins_sync)
    );

    ompc_map u_map (
        .boot_rom_enable_i(boot_q),
        .special_mode_i(special_mode_bit_q),
        .cpu_addr_i(cpu_addr_i),
        .boot_rom_sel_o(boot_rom_sel_o),
        .reset_vec_lo_o(reset_vec_lo_o),
        .reset_vec_hi_o(reset_vec_hi_o)
    );

    // write decode
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_hit = (awaddr_q[15:2] == OMPC_PRIO_MODE_ADDR[15:2]);

    // next value of the control register
    always_comb begin
        boot_d = boot_q;
        special_mode_bit_d = special_mode_bit_q;
        mda_d = mda_q;
        irv_d = irv_q;
        psel_d = psel_q;
        irv_done_d = irv_done_q;
        strap_d = strap_q;
        settle_d = settle_q;
        if (strap_q) begin
            // hold off until the pins have passed both flops after release
            if (settle_q != 2'h3) begin
                settle_d = settle_q + 2'h1;
            end else begin
                strap_d = 1'b0;
                special_mode_bit_d = ~pins_sync[1]; // [R07]
                mda_d = pins_sync[0]; // [R07]
                boot_d = ~pins_sync[1] & ~pins_sync[0]; // [R04] bootstrap only
                irv_d = ~pins_sync[1]; // [R04] both special modes
            end
        end else if (wr_fire && wr_hit && wstrb_q[0]) begin
            // each field checks its own permission, others still update [R12]
            if (special_mode_bit_q) begin
                boot_d = wdata_q[OMPC_BOOT_BIT]; // [R05]
                mda_d = wdata_q[OMPC_MDA_BIT]; // [R08]
                special_mode_bit_d = wdata_q[OMPC_SPECIAL_MODE_BIT_BIT]; // [R08] only clear reachable once zero [R09]
                irv_d = wdata_q[OMPC_IRV_BIT]; // [R10]
            end else if (!irv_done_q) begin
                irv_d = wdata_q[OMPC_IRV_BIT]; // [R10] first write only
            end
            // special_mode_bit of zero is sticky: a set attempt never passes above [R09]
            if (!special_mode_bit_q) begin
                irv_done_d = 1'b1; // [R10]
            end
            psel_d = wdata_q[OMPC_PSEL_MSB:0];
        end
    end

    // control register storage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            boot_q <= 1'b0;
            special_mode_bit_q <= 1'b0;
            mda_q <= 1'b0;
            irv_q <= 1'b0;
            psel_q <= OMPC_PSEL_RST; // [R04]
            irv_done_q <= 1'b0;
            strap_q <= 1'b1;
            settle_q <= 2'h0;
        end else begin
            boot_q <= boot_d;
            special_mode_bit_q <= special_mode_bit_d;
            mda_q <= mda_d;
            irv_q <= irv_d;
            psel_q <= psel_d;
            irv_done_q <= irv_done_d;
            strap_q <= strap_d;
            settle_q <= settle_d;
        end
    end

    // outputs derived from state
    assign mode_o = ompc_mode_t'({special_mode_bit_q, mda_q}); // [R04]
    assign mode_valid_o = !strap_q;
    assign prio_select_o = psel_q;
    // visibility only counts when an external bus exists [R11]
    assign read_visible_o = irv_q && mda_q && cpu_int_read_i && !strap_q; // [R11]

    // axi channel capture and response
    always_comb begin
        awaddr_d = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_have_d = w_have_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_have_d = 1'b1;
        end
        if (wr_fire) begin
            // writes during strap capture are dropped but still answered
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_hit ? OMPC_RESP_OKAY : OMPC_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            if (s_axi_araddr[15:2] == OMPC_PRIO_MODE_ADDR[15:2]) begin
                rdata_d = {24'h000000, pack_reg(boot_q, special_mode_bit_q, mda_q, irv_q, psel_q)}; // [R05] [R08]
                rresp_d = OMPC_RESP_OKAY;
            end else if (s_axi_araddr[15:2] == OMPC_STATUS_ADDR[15:2]) begin
                rdata_d = {29'h00000000, irv_done_q, mode_valid_o, boot_rom_sel_o};
                rresp_d = OMPC_RESP_OKAY;
            end else begin
                rdata_d = 32'h00000000;
                rresp_d = OMPC_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // axi state storage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            awaddr_q <= 16'h0000;
            aw_have_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= OMPC_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= OMPC_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            awaddr_q <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // one of each channel held at a time; ready is combinational
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule // ompc_top

/* File: tb/ompc_asserts.sv */
// checker for the mode and priority control block
// assumes it is bound to ompc_top and sees only its ports
`timescale 1ns/1ns
module ompc_asserts (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // pins and cpu side
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_int_read_i,
    input wire logic boot_rom_sel_o,
    input wire logic read_visible_o,
    input wire logic [15:0] reset_vec_lo_o,
    input wire logic [15:0] reset_vec_hi_o,
    input wire logic [3:0] prio_select_o,
    input wire ompc_pkg::ompc_mode_t mode_o,
    input wire logic mode_valid_o,
    // read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    import ompc_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // steps of a read and of the normal-mode state
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_normal;
        mode_valid_o && !mode_o[1];
    endsequence
    property p_rd_ans;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_vec_norm;
        !mode_o[1] |-> reset_vec_lo_o == OMPC_NORM_VEC_LO && reset_vec_hi_o == OMPC_NORM_VEC_HI;
    endproperty
    property p_vec_spec;
        mode_o[1] |-> reset_vec_lo_o == OMPC_SPEC_VEC_LO && reset_vec_hi_o == OMPC_SPEC_VEC_HI;
    endproperty
    property p_boot_win;
        boot_rom_sel_o |-> cpu_addr_i inside {[OMPC_BOOT_LO:OMPC_BOOT_HI]};
    endproperty
    property p_vis;
        read_visible_o |-> cpu_int_read_i && mode_o[0] && mode_valid_o;
    endproperty
    // pins are held steady by the bench across strap capture
    property p_strap;
        $rose(mode_valid_o) |-> mode_o == {~mode_pin_b_i, mode_pin_a_i};
    endproperty
    property p_psel_rst;
        $rose(mode_valid_o) |-> prio_select_o == OMPC_PSEL_RST;
    endproperty
    property p_special_mode_bit_once;
        s_normal |=> !mode_o[1];
    endproperty
    property p_norm_lock;
        s_normal |=> $stable(mode_o);
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_vec_norm: assert property (p_vec_norm) else $error("normal vector wrong");
    a_vec_spec: assert property (p_vec_spec) else $error("special vector wrong");
    a_boot_win: assert property (p_boot_win) else $error("boot select outside window");
    a_vis: assert property (p_vis) else $error("visibility without cause");
    a_strap: assert property (p_strap) else $error("strap capture wrong");
    a_psel_rst: assert property (p_psel_rst) else $error("priority reset wrong");
    a_special_mode_bit_once: assert property (p_special_mode_bit_once) else $error("special bit set again");
    a_norm_lock: assert property (p_norm_lock) else $error("mode changed in normal");
endmodule // ompc_asserts

bind ompc_top ompc_asserts i_ompc_asserts (.sys_clk_i, .sys_rst_i, .mode_pin_a_i, .mode_pin_b_i,
    .cpu_addr_i, .cpu_int_read_i, .boot_rom_sel_o, .read_visible_o, .reset_vec_lo_o, .reset_vec_hi_o,
    .prio_select_o, .mode_o, .mode_valid_o, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);

/* File: tb/tb_operating_mode_priority_control.sv */
// self-checking bench for the mode and priority control block
// assumes ompc_top alone, reached over axi4-lite with its pins driven here
`timescale 1ns/1ns
module tb_operating_mode_priority_control;
    import ompc_pkg::*;
    // clock, reset, pins, cpu side
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mode_pin_a_i = 1'b0;
    logic mode_pin_b_i = 1'b1;
    logic [15:0] cpu_addr_i = 16'hBF00;
    logic cpu_int_read_i = 1'b1;
    logic boot_rom_sel_o, read_visible_o, mode_valid_o;
    logic [15:0] reset_vec_lo_o, reset_vec_hi_o;
    logic [3:0] prio_select_o;
    ompc_mode_t mode_o;
    // axi4-lite
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0;
    int num_checks = 0;
    // per mode: reset value, two writes, value expected after each
    logic [7:0] rst_tab [4] = '{8'h06, 8'h26, 8'hD6, 8'h76};
    logic [7:0] wr_tab [4][2] = '{'{8'hFF, 8'h00}, '{8'hFF, 8'h00}, '{8'h00, 8'hFF}, '{8'hF5, 8'hC5}};
    logic [7:0] ex_tab [4][2] = '{'{8'h1F, 8'h10}, '{8'h3F, 8'h30}, '{8'h00, 8'h1F}, '{8'hF5, 8'hC5}};

    always #20 sys_clk_i = ~sys_clk_i;

    ompc_top i_dut (.sys_clk_i, .sys_rst_i, .mode_pin_a_i, .mode_pin_b_i, .cpu_addr_i, .cpu_int_read_i,
        .boot_rom_sel_o, .read_visible_o, .reset_vec_lo_o, .reset_vec_hi_o, .prio_select_o, .mode_o,
        .mode_valid_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // verdict and end of run
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a used-up wait bound ends the run as a failure
    task guard(input int n);
        if (n >= 40) begin
            n_mismatch++;
            test_done;
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        guard(n);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic axi_rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        guard(n);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, e});
        chk(32'(s_axi_rresp), 32'(er));
    endtask

    // strap pins for mode m, reset, wait for capture
    task automatic go_mode(input logic [1:0] m);
        int n;
        n = 0;
        mode_pin_b_i <= ~m[1];
        mode_pin_a_i <= m[0];
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (!mode_valid_o && n < 40);
        guard(n);
    endtask

    // register and every output that follows from it
    task automatic check_state(input logic [7:0] e);
        axi_rd(OMPC_PRIO_MODE_ADDR, e, OMPC_RESP_OKAY);
        chk(32'(mode_o), 32'(e[6:5]));
        chk(32'(prio_select_o), 32'(e[3:0]));
        chk(32'(read_visible_o), 32'(e[4] & e[5]));
        chk(32'(boot_rom_sel_o), 32'(e[7]));
        chk(32'(reset_vec_lo_o), e[6] ? 32'hBFFA : 32'hFFFA);
        chk(32'(reset_vec_hi_o), e[6] ? 32'hBFFF : 32'hFFFF);
        cpu_addr_i <= 16'hC000;
        @(posedge sys_clk_i);
        chk(32'(boot_rom_sel_o), 32'h0);
        cpu_addr_i <= 16'hBF00;
    endtask

    // each mode in turn, a second reset between them
    initial begin
        repeat (2) @(posedge sys_clk_i);
        for (int m = 0; m < 4; m++) begin
            go_mode(2'(m));
            check_state(rst_tab[m]);
            for (int k = 0; k < 2; k++) begin
                axi_wr(OMPC_PRIO_MODE_ADDR, wr_tab[m][k], 4'hF, OMPC_RESP_OKAY);
                check_state(ex_tab[m][k]);
            end
        end
        // unmapped place, then a write with byte 0 masked off
        axi_wr(16'h2000, 8'hFF, 4'hF, OMPC_RESP_SLVERR);
        axi_rd(16'h2000, 8'h00, OMPC_RESP_SLVERR);
        axi_wr(OMPC_PRIO_MODE_ADDR, 8'h00, 4'hE, OMPC_RESP_OKAY);
        check_state(8'hC5);
        // status: boot hit and strap valid, write-once not spent in special
        axi_rd(OMPC_STATUS_ADDR, 8'h03, OMPC_RESP_OKAY);
        test_done;
    end
endmodule // tb_operating_mode_priority_control
